// file: src/e1p_trunk_pins.sv
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module e1p_trunk_pins (
	input wire logic MCLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic SYSTEM_BIT_CLOCK_IN,
	input wire logic SYSTEM_FRAME_PULSE_N_IN,
	input wire logic SYS_DATA_IN,
	input wire logic CTRL_STREAM_IN_ZERO_IN,
	input wire logic CTRL_STREAM_IN_ONE_IN,
	output logic SYS_DATA_OUT,
	output logic CTRL_STREAM_OUT,
	input wire logic ALT_DIGIT_INV_SELECT_IN,
	input wire logic AUX_STATUS_IN,
	output logic AUX_CONTROL_OUT,
	input wire logic RECOVERED_BIT_CLOCK_IN,
	input wire logic LINE_RX_POS_IN,
	input wire logic LINE_RX_NEG_IN,
	input wire logic LINE_RX_DATA_IN,
	input wire logic LINE_RX_FRAME_MARK_IN,
	input wire logic LINE_SYNC_IN,
	output logic LINE_TX_POS_OUT,
	output logic LINE_TX_NEG_OUT,
	output logic RECOVERED_FRAME_CLK_OUT,
	output logic RECOVERED_FRAME_CLK_OE_OUT
);
	localparam int CW = e1p_pkg::CNT_W;

	function automatic logic [7:0] adi_apply(input logic [7:0] b, input logic en);
		adi_apply = en ? (b ^ e1p_pkg::ADI_MASK) : b;
	endfunction

	function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] pos);
		pick_bit = b[3'h7 - pos];
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [6:0] s_lvl;
	logic [6:0] s_rise;
	logic [6:0] s_fall;
	logic [5:0] l_lvl;
	logic [5:0] l_fall;

	// Frame pulse enters inverted so the cleared stages mean no pulse
	e1p_pin_sync #(.WIDTH(7)) u_sys_sync (
		.clk_in(MCLK_IN),
		.rst_in(SYS_RST_IN),
		.pins_in({AUX_STATUS_IN, ALT_DIGIT_INV_SELECT_IN, CTRL_STREAM_IN_ONE_IN,
			CTRL_STREAM_IN_ZERO_IN, SYS_DATA_IN, ~SYSTEM_FRAME_PULSE_N_IN, SYSTEM_BIT_CLOCK_IN}),
		.level_out(s_lvl),
		.rise_out(s_rise),
		.fall_out(s_fall)
	);

	e1p_pin_sync #(.WIDTH(6)) u_line_sync (
		.clk_in(MCLK_IN),
		.rst_in(SYS_RST_IN),
		.pins_in({LINE_SYNC_IN, LINE_RX_FRAME_MARK_IN, LINE_RX_DATA_IN, LINE_RX_NEG_IN,
			LINE_RX_POS_IN, RECOVERED_BIT_CLOCK_IN}),
		.level_out(l_lvl),
		.rise_out(),
		.fall_out(l_fall)
	);

	logic sclk_fall;
	logic sclk_rise;
	logic rclk_fall;
	logic line_synced;
	assign sclk_fall = s_fall[0];
	assign sclk_rise = s_rise[0];
	assign rclk_fall = l_fall[0];
	assign line_synced = l_lvl[5];

	// ****************************************
	// Register bus
	// ****************************************
	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] master_control_word_two_q;
	logic [7:0] ctrl1_w0_q;
	logic aux_stat_q;
	logic aux_ctrl_q;

	always_comb
	begin
		ctrl_d = ctrl_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if ((AVS_READ_IN || AVS_WRITE_IN) && wait_q)
		begin
			wait_d = 1'b0;
			unique case (AVS_ADDRESS_IN)
				e1p_pkg::REG_CTRL: rdata_d = {30'h0, ctrl_q};
				e1p_pkg::REG_STATUS: rdata_d = {8'h0, ctrl1_w0_q, master_control_word_two_q, 4'h0,
					RECOVERED_FRAME_CLK_OE_OUT, aux_ctrl_q, aux_stat_q, line_synced};
				default: rdata_d = e1p_pkg::UNMAPPED_READ;
			endcase
		end
		if (AVS_WRITE_IN && !wait_q && AVS_ADDRESS_IN == e1p_pkg::REG_CTRL)
			ctrl_d = AVS_WRITEDATA_IN[1:0];
	end

	always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			ctrl_q <= e1p_pkg::CTRL_RESET;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign AVS_WAITREQUEST_OUT = wait_q;
	assign AVS_READDATA_OUT = rdata_q;

	// ****************************************
	// System side streams
	// ****************************************
	logic [7:0] rx_mem [0:e1p_pkg::SLOTS-1];
	logic [7:0] tx_mem [0:e1p_pkg::SLOTS-1];
	logic [e1p_pkg::SLOTS-1:0] voice_q;
	logic [e1p_pkg::SLOTS-1:0] voice_d;
	logic [CW-1:0] scnt_q;
	logic [CW-1:0] scnt_d;
	logic [7:0] sh_dat_q;
	logic [7:0] sh_dat_d;
	logic [7:0] sh_c0_q;
	logic [7:0] sh_c0_d;
	logic [7:0] sh_c1_q;
	logic [7:0] sh_c1_d;
	logic [7:0] master_control_word_two_d;
	logic [7:0] ctrl1_w0_d;
	logic aux_stat_d;
	logic aux_ctrl_d;
	logic sdo_q;
	logic sdo_d;
	logic cso_q;
	logic cso_d;
	logic tx_we;
	logic [7:0] tx_wdata;
	logic [4:0] sslot;
	logic [7:0] dat_word;
	logic [7:0] c0_word;
	logic [7:0] msw1;
	logic adi_on;
	assign sslot = scnt_q[7:3];
	assign adi_on = s_lvl[5];
	assign dat_word = {sh_dat_q[6:0], s_lvl[2]};
	assign c0_word = {sh_c0_q[6:0], s_lvl[3]};

	always_comb
	begin
		scnt_d = scnt_q;
		sh_dat_d = sh_dat_q;
		sh_c0_d = sh_c0_q;
		sh_c1_d = sh_c1_q;
		voice_d = voice_q;
		master_control_word_two_d = master_control_word_two_q;
		ctrl1_w0_d = ctrl1_w0_q;
		aux_stat_d = aux_stat_q;
		aux_ctrl_d = aux_ctrl_q;
		sdo_d = sdo_q;
		cso_d = cso_q;
		tx_we = 1'b0;
		tx_wdata = adi_apply(dat_word, adi_on && voice_q[sslot]);
		msw1 = 8'h00;
		msw1[e1p_pkg::MSW1_AUX_STAT_BIT] = aux_stat_q;
		msw1[e1p_pkg::MSW1_SYNC_BIT] = line_synced;
		if (sclk_fall)
		begin
			sh_dat_d = dat_word;
			sh_c0_d = c0_word;
			sh_c1_d = {sh_c1_q[6:0], s_lvl[4]};
			if (scnt_q[2:0] == 3'h7)
			begin
				tx_we = 1'b1;
				if (sslot == e1p_pkg::SLOT_MASTER_CONTROL_WORD_TWO)
					master_control_word_two_d = c0_word;
				else if (sslot != e1p_pkg::SLOT_MCW1)
					voice_d[sslot] = c0_word[e1p_pkg::PCW_VOICE_BIT];
				if (sslot == 5'h00)
					ctrl1_w0_d = {sh_c1_q[6:0], s_lvl[4]};
			end
			scnt_d = scnt_q + 8'h01;
			// Frame pulse realigns; aux control and aux status update here only
			if (s_lvl[1])
			begin
				scnt_d = 8'h00;
				aux_ctrl_d = master_control_word_two_q[e1p_pkg::MASTER_CONTROL_WORD_TWO_AUX_CTRL_BIT];
				aux_stat_d = s_lvl[6];
			end
		end
		if (sclk_rise)
		begin
			sdo_d = pick_bit(adi_apply(rx_mem[sslot], adi_on && voice_q[sslot]),
				scnt_q[2:0]);
			cso_d = (sslot == e1p_pkg::SLOT_MSW1) ? pick_bit(msw1, scnt_q[2:0]) : 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			scnt_q <= 8'h00;
			sh_dat_q <= 8'h00;
			sh_c0_q <= 8'h00;
			sh_c1_q <= 8'h00;
			voice_q <= '0;
			master_control_word_two_q <= 8'h00;
			ctrl1_w0_q <= 8'h00;
			aux_stat_q <= 1'b0;
			aux_ctrl_q <= 1'b0;
			sdo_q <= 1'b0;
			cso_q <= 1'b0;
		end
		else
		begin
			scnt_q <= scnt_d;
			sh_dat_q <= sh_dat_d;
			sh_c0_q <= sh_c0_d;
			sh_c1_q <= sh_c1_d;
			voice_q <= voice_d;
			master_control_word_two_q <= master_control_word_two_d;
			ctrl1_w0_q <= ctrl1_w0_d;
			aux_stat_q <= aux_stat_d;
			aux_ctrl_q <= aux_ctrl_d;
			sdo_q <= sdo_d;
			cso_q <= cso_d;
		end
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (tx_we)
			tx_mem[sslot] <= tx_wdata;
	end

	assign SYS_DATA_OUT = sdo_q;
	assign CTRL_STREAM_OUT = cso_q;
	assign AUX_CONTROL_OUT = aux_ctrl_q;

	// ****************************************
	// Line transmit
	// ****************************************
	logic txp_q;
	logic txp_d;
	logic txn_q;
	logic txn_d;
	logic pol_q;
	logic pol_d;
	logic tx_mark;
	// Bit launched at the same system fall that samples the stream
	assign tx_mark = pick_bit(tx_mem[sslot], scnt_q[2:0]);

	always_comb
	begin
		txp_d = txp_q;
		txn_d = txn_q;
		pol_d = pol_q;
		if (sclk_fall)
		begin
			// Marks alternate between the two rails for the bipolar driver
			txp_d = ctrl_q[e1p_pkg::CTRL_TX_EN_BIT] && tx_mark && !pol_q;
			txn_d = ctrl_q[e1p_pkg::CTRL_TX_EN_BIT] && tx_mark && pol_q;
			if (ctrl_q[e1p_pkg::CTRL_TX_EN_BIT] && tx_mark)
				pol_d = !pol_q;
		end
	end

	always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			txp_q <= 1'b0;
			txn_q <= 1'b0;
			pol_q <= 1'b0;
		end
		else
		begin
			txp_q <= txp_d;
			txn_q <= txn_d;
			pol_q <= pol_d;
		end
	end

	assign LINE_TX_POS_OUT = txp_q;
	assign LINE_TX_NEG_OUT = txn_q;

	// ****************************************
	// Line receive and frame clock
	// ****************************************
	logic [CW-1:0] rcnt_q;
	logic [CW-1:0] rcnt_d;
	logic [7:0] sh_rx_q;
	logic [7:0] sh_rx_d;
	logic fclk_q;
	logic fclk_d;
	logic fclk_oe_q;
	logic fclk_oe_d;
	logic rx_we;
	logic rx_bit;
	logic [CW-1:0] rcnt_next;

	// Sampling mid-bit makes RZ and NRZ look alike
	assign rx_bit = ctrl_q[e1p_pkg::CTRL_RX_UNI_BIT] ? l_lvl[3] : (l_lvl[1] | l_lvl[2]);
	assign rcnt_next = l_lvl[4] ? 8'h00 : rcnt_q + 8'h01;

	always_comb
	begin
		rcnt_d = rcnt_q;
		sh_rx_d = sh_rx_q;
		rx_we = 1'b0;
		if (rclk_fall)
		begin
			sh_rx_d = {sh_rx_q[6:0], rx_bit};
			rx_we = (rcnt_q[2:0] == 3'h7);
			rcnt_d = rcnt_next;
		end
		// High for the first half of each 256-bit line frame
		fclk_d = line_synced && (rcnt_q < e1p_pkg::FCLK_HIGH_BITS);
		fclk_oe_d = master_control_word_two_q[e1p_pkg::MASTER_CONTROL_WORD_TWO_FCLK_EN_BIT];
	end

	always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			rcnt_q <= 8'h00;
			sh_rx_q <= 8'h00;
			fclk_q <= 1'b0;
			fclk_oe_q <= 1'b0;
		end
		else
		begin
			rcnt_q <= rcnt_d;
			sh_rx_q <= sh_rx_d;
			fclk_q <= fclk_d;
			fclk_oe_q <= fclk_oe_d;
		end
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (rx_we)
			rx_mem[rcnt_q[7:3]] <= {sh_rx_q[6:0], rx_bit};
	end

	assign RECOVERED_FRAME_CLK_OUT = fclk_q;
	assign RECOVERED_FRAME_CLK_OE_OUT = fclk_oe_q;
endmodule

// file: src/e1p_pkg.sv
// Contract
// - Frame clock is recovered clock divided by 256
// - Frame clock low without line synchronization
// - Frame clock floats when select bit clear
// - Aux control output follows control bit one
// - Aux control output changes once per frame
// - Aux status sampled per frame, reported
// - Voice slots inverted both ways when selected
// - No inversion when select input low
// - Recovered channels output on system data
// - Receive data accepted as NRZ or RZ
// - Two split-phase unipolar transmit outputs
// - Two split-phase unipolar receive inputs
// - Streams sampled falling, launched rising edge
// - Line data latched on recovered clock fall
// - Control output stream carries status words
package e1p_pkg;
	// ****************************************
	// Stream geometry
	// ****************************************
	localparam int BITS_PER_FRAME = 256;
	localparam int CNT_W = 8;
	localparam int SLOTS = 32;
	localparam logic [4:0] SLOT_MCW1 = 5'h00;
	localparam logic [4:0] SLOT_MASTER_CONTROL_WORD_TWO = 5'h10;
	localparam logic [4:0] SLOT_MSW1 = 5'h00;
	localparam int MASTER_CONTROL_WORD_TWO_AUX_CTRL_BIT = 1;
	localparam int MASTER_CONTROL_WORD_TWO_FCLK_EN_BIT = 3;
	localparam int PCW_VOICE_BIT = 0;
	localparam int MSW1_AUX_STAT_BIT = 1;
	localparam int MSW1_SYNC_BIT = 0;
	localparam logic [7:0] ADI_MASK = 8'h55;
	localparam logic [CNT_W-1:0] FCLK_HIGH_BITS = 8'h80;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_RX_UNI_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// file: src/e1p_pin_sync.sv
`timescale 1ns/100ps
module e1p_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out,
	output logic [WIDTH-1:0] fall_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;

	// Edge detect compares the second stage with the third (prev_q)
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			meta_q <= pins_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
	assign fall_out = ~sync_q & prev_q;
endmodule

// file: verif/e1p_trunk_props.sv
`timescale 1ns/100ps
module e1p_trunk_props (
	input wire logic MCLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic SYSTEM_BIT_CLOCK_IN,
	input wire logic RECOVERED_BIT_CLOCK_IN,
	input wire logic LINE_SYNC_IN,
	input wire logic AUX_CONTROL_OUT,
	input wire logic LINE_TX_POS_OUT,
	input wire logic LINE_TX_NEG_OUT,
	input wire logic RECOVERED_FRAME_CLK_OUT
);
	// ****
	// Pin edge counters
	// ****
	logic s_q, r_q, per_ok_q;
	logic [8:0] s_cnt_q, r_cnt_q;
	logic [3:0] since_q;
	wire logic s_fall = s_q && !SYSTEM_BIT_CLOCK_IN;
	wire logic r_fall = r_q && !RECOVERED_BIT_CLOCK_IN;
	always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			s_q <= 1'b0;
			r_q <= 1'b0;
			per_ok_q <= 1'b0;
			s_cnt_q <= 9'h1ff;
			r_cnt_q <= 9'h000;
			since_q <= 4'hf;
		end
		else
		begin
			s_q <= SYSTEM_BIT_CLOCK_IN;
			r_q <= RECOVERED_BIT_CLOCK_IN;
			// Starts saturated, so the first update after reset passes
			if ($changed(AUX_CONTROL_OUT))
				s_cnt_q <= 9'h000;
			else if (s_fall && s_cnt_q != 9'h1ff)
				s_cnt_q <= s_cnt_q + 9'h001;
			since_q <= s_fall ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
			r_cnt_q <= $rose(RECOVERED_FRAME_CLK_OUT) ? {8'h00, r_fall} : r_cnt_q + {8'h00, r_fall};
			// First period after sync may be partial, so it is skipped
			per_ok_q <= LINE_SYNC_IN && (per_ok_q || $rose(RECOVERED_FRAME_CLK_OUT));
		end
	end
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	sequence seq_take;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
	endsequence
	sequence seq_answer;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence
	chk_bus_answer: assert property (seq_take |=> seq_answer)
		else $error("bus request not answered in one cycle");
	chk_bus_idle: assert property (!(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
		|=> AVS_WAITREQUEST_OUT) else $error("waitrequest dropped while idle");
	chk_answer_cause: assert property ($fell(AVS_WAITREQUEST_OUT)
		|-> $past(AVS_READ_IN) || $past(AVS_WRITE_IN)) else $error("answer without request");
	chk_fclk_nosync: assert property (!LINE_SYNC_IN [*5] |-> !RECOVERED_FRAME_CLK_OUT)
		else $error("frame clock high without sync");
	chk_tx_rails: assert property (!(LINE_TX_POS_OUT && LINE_TX_NEG_OUT))
		else $error("both transmit rails high");
	chk_aux_once: assert property ($changed(AUX_CONTROL_OUT) |-> s_cnt_q >= 9'h0ff)
		else $error("aux control changed twice in a frame");
	chk_aux_frame: assert property ($changed(AUX_CONTROL_OUT) |-> since_q <= 4'h8)
		else $error("aux control changed away from frame point");
	chk_fclk_period: assert property ($rose(RECOVERED_FRAME_CLK_OUT) && per_ok_q
		|-> r_cnt_q == 9'h100) else $error("frame clock period not 256 bits");
endmodule

bind e1p_trunk_pins e1p_trunk_props chk_u (
	.MCLK_IN(MCLK_IN),
	.SYS_RST_IN(SYS_RST_IN),
	.AVS_READ_IN(AVS_READ_IN),
	.AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.SYSTEM_BIT_CLOCK_IN(SYSTEM_BIT_CLOCK_IN),
	.RECOVERED_BIT_CLOCK_IN(RECOVERED_BIT_CLOCK_IN),
	.LINE_SYNC_IN(LINE_SYNC_IN),
	.AUX_CONTROL_OUT(AUX_CONTROL_OUT),
	.LINE_TX_POS_OUT(LINE_TX_POS_OUT),
	.LINE_TX_NEG_OUT(LINE_TX_NEG_OUT),
	.RECOVERED_FRAME_CLK_OUT(RECOVERED_FRAME_CLK_OUT)
);

// file: verif/e1p_far_model.sv
`timescale 1ns/100ps
module e1p_far_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] master_control_word_two_in,
	output logic sys_clk_out,
	output logic frame_pulse_n_out,
	output logic ctrl_zero_out,
	output logic ctrl_one_out,
	output logic sys_data_out,
	output logic rec_clk_out,
	output logic frame_mark_out,
	output logic rx_pos_out,
	output logic rx_neg_out
);
	// ****
	// Bit timing, twelve MCLK per bit
	// ****
	logic [3:0] ph_q;
	logic [7:0] bit_q;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ph_q <= 4'h0;
			bit_q <= 8'hff;
		end
		else
		begin
			ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
			if (ph_q == 4'hb)
				bit_q <= bit_q + 8'h01;
		end
	end
	// Slightly fast bit rate, traded for whole MCLK counts per bit
	assign sys_clk_out = ph_q < 4'h6;
	assign frame_pulse_n_out = bit_q != 8'hff;
	// Slot 16 carries the control word; odd slots are flagged voice
	assign ctrl_zero_out = (bit_q[7:3] == 5'h10) ? master_control_word_two_in[~bit_q[2:0]]
		: (bit_q[3] && bit_q[2:0] == 3'h7);
	assign ctrl_one_out = bit_q[2];
	assign sys_data_out = bit_q[1];
	assign rec_clk_out = sys_clk_out;
	assign frame_mark_out = bit_q == 8'hff;
	assign rx_pos_out = bit_q[1] && bit_q[0];
	assign rx_neg_out = bit_q[1] && !bit_q[0];
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
	logic mclk, rst, rd, wr, alt_digit_inv_select, aux_st, sync, mon, uni, seen_mark, last_pos;
	logic [3:0] addr;
	logic [31:0] wdata, q;
	logic [7:0] master_control_word_two;
	wire logic [31:0] rdata;
	wire logic waitreq, s_clk, fp_n, cs0, cs1, sdin, r_clk, fmark, rxp, rxn;
	wire logic auxc, txp, txn, fclk, fclk_oe, sdout, csout;
	int error_cnt, checked, hi_cnt;
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	e1p_far_model far_u (.clk_in(mclk), .rst_in(rst), .master_control_word_two_in(master_control_word_two), .sys_clk_out(s_clk),
		.frame_pulse_n_out(fp_n), .ctrl_zero_out(cs0), .ctrl_one_out(cs1), .sys_data_out(sdin),
		.rec_clk_out(r_clk), .frame_mark_out(fmark), .rx_pos_out(rxp), .rx_neg_out(rxn));
	e1p_trunk_pins dut_u (.MCLK_IN(mclk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .SYSTEM_BIT_CLOCK_IN(s_clk), .SYSTEM_FRAME_PULSE_N_IN(fp_n),
		.SYS_DATA_IN(sdin), .CTRL_STREAM_IN_ZERO_IN(cs0), .CTRL_STREAM_IN_ONE_IN(cs1),
		.SYS_DATA_OUT(sdout), .CTRL_STREAM_OUT(csout), .ALT_DIGIT_INV_SELECT_IN(alt_digit_inv_select),
		.AUX_STATUS_IN(aux_st), .AUX_CONTROL_OUT(auxc), .RECOVERED_BIT_CLOCK_IN(r_clk),
		.LINE_RX_POS_IN(rxp), .LINE_RX_NEG_IN(rxn), .LINE_RX_DATA_IN(cs1),
		.LINE_RX_FRAME_MARK_IN(fmark), .LINE_SYNC_IN(sync), .LINE_TX_POS_OUT(txp),
		.LINE_TX_NEG_OUT(txn), .RECOVERED_FRAME_CLK_OUT(fclk), .RECOVERED_FRAME_CLK_OE_OUT(fclk_oe));
	always @(posedge mclk)
		if (fclk === 1'b1)
			hi_cnt++;
	// ****
	// Stream monitor
	// ****
	// Outputs stand settled at each system clock fall; line bytes loop one frame late
	always @(negedge s_clk)
	begin
		logic [7:0] k;
		logic [7:0] j;
		logic [7:0] rx_byte;
		logic [7:0] tx_byte;
		logic cs_exp;
		k = far_u.bit_q;
		j = k - 8'h01;
		// Rails carry 0x33 and the data pin 0x0f in every slot
		rx_byte = uni ? 8'h0f : 8'h33;
		tx_byte = 8'h33;
		if (alt_digit_inv_select && k[3])
			rx_byte = rx_byte ^ e1p_pkg::ADI_MASK;
		if (alt_digit_inv_select && j[3])
			tx_byte = tx_byte ^ e1p_pkg::ADI_MASK;
		cs_exp = (k == 8'h06) ? aux_st : ((k == 8'h07) ? sync : 1'b0);
		if (mon !== 1'b1)
			seen_mark = 1'b0;
		else
		begin
			chk("system data out", rx_byte[3'h7 - k[2:0]], sdout);
			chk("control stream out", cs_exp, csout);
			chk("line mark", tx_byte[3'h7 - j[2:0]], txp | txn);
			if ((txp | txn) && seen_mark)
				chk("mark polarity", !last_pos, txp);
			if (txp | txn)
			begin
				seen_mark = 1'b1;
				last_pos = txp;
			end
		end
	end
	// ****
	// Tasks
	// ****
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		// Values seen here are those sampled by the rising edge
		@(posedge mclk);
		while (waitreq !== 1'b0)
			@(posedge mclk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic frames(input int n);
		repeat (n * 3072) @(posedge mclk);
	endtask
	task give_verdict;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial
	begin
		#2000000;
		error_cnt++;
		give_verdict;
	end
	initial
	begin
		error_cnt = 0;
		checked = 0;
		hi_cnt = 0;
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		alt_digit_inv_select = 1'b0;
		aux_st = 1'b0;
		sync = 1'b0;
		mon = 1'b0;
		uni = 1'b0;
		seen_mark = 1'b0;
		last_pos = 1'b0;
		master_control_word_two = 8'h0a;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", 32'h1, q);
		bus(1'b1, 4'h8, 32'h3);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped read", 32'h0, q);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl kept", 32'h1, q);
		frames(2);
		chk("frame clock unsynced", 32'h0, hi_cnt);
		chk("frame clock enable", 32'h1, fclk_oe);
		// Streams need two settled frames before the monitor looks
		mon <= 1'b1;
		frames(1);
		mon <= 1'b0;
		aux_st <= 1'b1;
		sync <= 1'b1;
		alt_digit_inv_select <= 1'b1;
		frames(2);
		mon <= 1'b1;
		frames(1);
		chk("frame clock synced", 32'h1, hi_cnt > 0);
		chk("aux control set", 32'h1, auxc);
		bus(1'b0, 4'h4, 32'h0);
		chk("status aux input", 32'h1, q[1]);
		chk("status control word", 32'h0a, q[15:8]);
		mon <= 1'b0;
		master_control_word_two <= 8'h00;
		aux_st <= 1'b0;
		uni <= 1'b1;
		bus(1'b1, 4'h0, 32'h3);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl unipolar", 32'h3, q);
		frames(2);
		mon <= 1'b1;
		frames(1);
		chk("aux control clear", 32'h0, auxc);
		chk("frame clock float", 32'h0, fclk_oe);
		bus(1'b0, 4'h4, 32'h0);
		chk("status aux input", 32'h0, q[1]);
		mon <= 1'b0;
		sync <= 1'b0;
		frames(1);
		chk("frame clock lost sync", 32'h0, fclk);
		give_verdict;
	end
endmodule
